// *** rtl/gtm_pkg.sv ***
// constants shared by the gated timer block
package gtm_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] OFF_TIMER_CTRL = 3'h0;
  localparam logic [2:0] OFF_GATE_CTRL  = 3'h1;
  localparam logic [2:0] OFF_COUNT_LOW  = 3'h2;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFF_FLAGS      = 3'h4;
  localparam logic [2:0] OFF_ENABLES    = 3'h5;
  localparam logic [2:0] OFF_CCV_LOW    = 3'h6;
  localparam logic [2:0] OFF_CCV_HIGH   = 3'h7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TC_CS_LSB   = 6;   // clock_source_select [7:6]
  localparam int TC_SOSC     = 3;   // secondary_osc_enable
  localparam int TC_SYNC_DIS = 2;   // sync_disable
  localparam int TC_ON       = 0;   // counter_on
  localparam int GC_MODE     = 7;   // gate_mode_enable
  localparam int GC_POL      = 6;   // gate_polarity
  localparam int GC_TOG      = 5;   // gate_toggle_enable
  localparam int GC_SP       = 4;   // gate_single_pulse_enable
  localparam int GC_ARM      = 3;   // gate_pulse_arm
  localparam int GC_LEVEL    = 2;   // gate_level, read only
  localparam int GC_SS_LSB   = 0;   // gate_source_select [1:0]
  localparam int FL_GEV      = 1;   // gate_event_flag
  localparam int FL_OVF      = 0;   // overflow_flag
  localparam int EN_GIE      = 7;   // global_irq_enable
  localparam int EN_PIE      = 6;   // peripheral_irq_enable
  localparam int EN_C2SYNC   = 3;   // comparator 2 synchronised
  localparam int EN_C1SYNC   = 2;   // comparator 1 synchronised
  localparam int EN_GEVIE    = 1;   // gate_event_irq_enable
  localparam int EN_OVFIE    = 0;   // overflow_irq_enable

  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [1:0] SRC_PIN  = 2'h0;
  localparam logic [1:0] SRC_TMR0 = 2'h1;
  localparam logic [1:0] SRC_CMP1 = 2'h2;
  localparam logic [1:0] SRC_CMP2 = 2'h3;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
endpackage : gtm_pkg

// *** rtl/gtm_sync.sv ***
// three-stage input synchroniser with agreement filter
module gtm_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // output follows only once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) q_o <= s3_r;
    end
  end
endmodule // gtm_sync

// *** rtl/gtm_gate.sv ***
// gate toggle, single-pulse and edge logic
module gtm_gate (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic src_i,
  input  wire logic pol_i,
  input  wire logic tog_en_i,
  input  wire logic sp_en_i,
  input  wire logic arm_i,
  output logic      level_o,
  output logic      ok_o,
  output logic      fall_o,
  output logic      done_o
);
  logic src_p;
  logic src_q_r;
  logic tff_r;
  logic lvl_q_r;
  logic started_r;
  logic rise;

  // polarity first, so high always means the counting level
  assign src_p   = pol_i ? src_i : ~src_i;
  assign level_o = tog_en_i ? tff_r : src_p;
  assign rise    = level_o & ~lvl_q_r;
  assign fall_o  = ~level_o & lvl_q_r;
  assign done_o  = sp_en_i & arm_i & started_r & fall_o;
  // single pulse passes counting only from the armed rising edge
  assign ok_o = sp_en_i ? (arm_i & (started_r | rise) & level_o)
                        : level_o;

  // toggle flop held clear while toggle mode is off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tff_r   <= 1'b0;
      src_q_r <= 1'b0;
    end else begin
      src_q_r <= src_p;
      if (!tog_en_i) tff_r <= 1'b0;
      else if (src_p & ~src_q_r) tff_r <= ~tff_r;
    end
  end

  // registered level copy and single-pulse start marker
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_q_r   <= 1'b0;
      started_r <= 1'b0;
    end else begin
      lvl_q_r <= level_o;
      if (!(sp_en_i & arm_i) | done_o) started_r <= 1'b0;
      else if (rise) started_r <= 1'b1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  toggle_held_a: assert property (
    !tog_en_i |=> !tff_r) else $error("toggle flop not held clear");
  toggle_flip_a: assert property (
    tog_en_i && $past(tog_en_i) && $rose(src_p) |=> tff_r != $past(tff_r))
    else $error("toggle flop missed an incrementing edge");
  pulse_block_a: assert property (
    sp_en_i && !arm_i |-> !ok_o) else $error("count passed while disarmed");
endmodule // gtm_gate

// *** rtl/gtm_timer.sv ***
// gated 16-bit timer: gate logic, flags, capture/compare time base
//
// Contract
// - Comparator gate sources pass synchronised or direct, per setting.
// - Toggle mode routes gate source through flop inverting per rising edge.
// - Toggle mode off forces and holds the toggle flop at zero.
// - Single pulse: enable, then arm; counting starts next gate edge.
// - Arm bit clears itself at the trailing edge of the pulse.
// - Disarmed, all further gate events are ignored for counting.
// - Toggle and single pulse together capture one full gate cycle.
// - Gate level is readable, even with gate mode disabled.
// - Falling gate level sets the gate event flag.
// - Gate interrupt needs gate event flag and its enable.
// - Gate event flag works while gate mode is disabled.
// - Counter wraps from maximum to zero, setting overflow flag.
// - In sleep, counting only in asynchronous external counter mode.
// - Overflow in sleep wakes; vectoring only with global enable.
// - Secondary oscillator keeps running in sleep regardless of sync.
// - Capture copies counter; compare fires when value equals counter.
// - Conversion trigger clears counter without raising overflow.
// - Counter write coinciding with trigger clear takes precedence.
// - Source select: gate pin, timer0 overflow, comparator 1, 2.
// - Gate mode: count only while gate level matches polarity.
// - Off when counter on is zero; else free or gated.
//
// The address map and the address-and-strobe port were left to the implementer.
module gtm_timer (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [2:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic        GATE_PIN_I,
  input  wire logic        EXT_COUNT_I,
  input  wire logic        TMR0_OVF_I,
  input  wire logic        CMP1_I,
  input  wire logic        CMP2_I,
  input  wire logic        SLEEP_I,
  input  wire logic        CAPTURE_I,
  input  wire logic        CONV_TRIG_I,
  output logic      [15:0] COUNT_O,
  output logic             COMPARE_O,
  output logic             IRQ_O,
  output logic             WAKE_O,
  output logic             SOSC_RUN_O
);
  // ****************************************
  // registers and wires
  // ****************************************
  logic [7:0]  tctl_r;
  logic [7:0]  gctl_r;
  logic [7:0]  en_r;
  logic        ovf_r;
  logic        gev_r;
  logic        arm_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] ccv_r;
  logic        eq_q_r;
  logic        pin_s;
  logic        ext_s;
  logic        ext_q_r;
  logic        c1_s;
  logic        c2_s;
  logic        c1_g;
  logic        c2_g;
  logic        gate_src;
  logic        gate_lvl;
  logic        gate_ok;
  logic        gate_fall;
  logic        gate_done;
  logic        wr_tc;
  logic        wr_gc;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_fl;
  logic        wr_en;
  logic        wr_cl;
  logic        wr_ch;
  logic        wr_cnt;
  logic        async_ext;
  logic        tick;
  logic        run;
  logic        inc;
  logic        wrap;
  logic        eq_w;
  logic [7:0]  rd_mux;

  // ****************************************
  // input synchronisers
  // ****************************************
  // pins and comparator outputs arrive from outside this clock
  gtm_sync u_pin (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .d_i    (GATE_PIN_I),
    .q_o    (pin_s)
  );
  gtm_sync u_ext (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .d_i    (EXT_COUNT_I),
    .q_o    (ext_s)
  );
  gtm_sync u_c1 (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .d_i    (CMP1_I),
    .q_o    (c1_s)
  );
  gtm_sync u_c2 (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .d_i    (CMP2_I),
    .q_o    (c2_s)
  );

  // ****************************************
  // gate source selection
  // ****************************************
  // direct path is faster but may glitch the gate mid-cycle
  assign c1_g = en_r[gtm_pkg::EN_C1SYNC] ? c1_s : CMP1_I;
  assign c2_g = en_r[gtm_pkg::EN_C2SYNC] ? c2_s : CMP2_I;
  assign gate_src =
    (gctl_r[1:0] == gtm_pkg::SRC_PIN)  ? pin_s :
    (gctl_r[1:0] == gtm_pkg::SRC_TMR0) ? TMR0_OVF_I :
    (gctl_r[1:0] == gtm_pkg::SRC_CMP1) ? c1_g : c2_g;

  gtm_gate u_gate (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .src_i    (gate_src),
    .pol_i    (gctl_r[gtm_pkg::GC_POL]),
    .tog_en_i (gctl_r[gtm_pkg::GC_TOG]),
    .sp_en_i  (gctl_r[gtm_pkg::GC_SP]),
    .arm_i    (arm_r),
    .level_o  (gate_lvl),
    .ok_o     (gate_ok),
    .fall_o   (gate_fall),
    .done_o   (gate_done)
  );

  // ****************************************
  // register decode
  // ****************************************
  assign wr_tc  = WR_I & (ADDR_I == gtm_pkg::OFF_TIMER_CTRL);
  assign wr_gc  = WR_I & (ADDR_I == gtm_pkg::OFF_GATE_CTRL);
  assign wr_lo  = WR_I & (ADDR_I == gtm_pkg::OFF_COUNT_LOW);
  assign wr_hi  = WR_I & (ADDR_I == gtm_pkg::OFF_COUNT_HIGH);
  assign wr_fl  = WR_I & (ADDR_I == gtm_pkg::OFF_FLAGS);
  assign wr_en  = WR_I & (ADDR_I == gtm_pkg::OFF_ENABLES);
  assign wr_cl  = WR_I & (ADDR_I == gtm_pkg::OFF_CCV_LOW);
  assign wr_ch  = WR_I & (ADDR_I == gtm_pkg::OFF_CCV_HIGH);
  assign wr_cnt = wr_lo | wr_hi;

  // read mux; gate level reads live even with gate mode off
  assign rd_mux =
    (ADDR_I == gtm_pkg::OFF_TIMER_CTRL) ? tctl_r :
    (ADDR_I == gtm_pkg::OFF_GATE_CTRL)  ?
      {gctl_r[7:4], arm_r, gate_lvl, gctl_r[1:0]} :
    (ADDR_I == gtm_pkg::OFF_COUNT_LOW)  ? cnt_r[7:0] :
    (ADDR_I == gtm_pkg::OFF_COUNT_HIGH) ? cnt_r[15:8] :
    (ADDR_I == gtm_pkg::OFF_FLAGS)      ? {6'h00, gev_r, ovf_r} :
    (ADDR_I == gtm_pkg::OFF_ENABLES)    ? en_r :
    (ADDR_I == gtm_pkg::OFF_CCV_LOW)    ? ccv_r[7:0] : ccv_r[15:8];

  // read data valid the cycle after the strobe only
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) RDATA_O <= gtm_pkg::RST_BYTE;
    else RDATA_O <= RD_I ? rd_mux : gtm_pkg::RST_BYTE;
  end

  // control registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tctl_r <= gtm_pkg::RST_BYTE;
      gctl_r <= gtm_pkg::RST_BYTE;
      en_r   <= gtm_pkg::RST_BYTE;
    end else begin
      if (wr_tc) tctl_r <= WDATA_I & 8'hFD; // bit 1 unimplemented
      if (wr_gc) gctl_r <= WDATA_I;
      if (wr_en) en_r <= WDATA_I;
    end
  end

  // arm: software write beats the self-clear, so a re-arm sticks
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) arm_r <= 1'b0;
    else if (wr_gc) arm_r <= WDATA_I[gtm_pkg::GC_ARM];
    else if (gate_done) arm_r <= 1'b0;
  end

  // ****************************************
  // counter
  // ****************************************
  // asynchronous mode is modelled on the synchronised pin edge
  assign async_ext = tctl_r[gtm_pkg::TC_SYNC_DIS] &
    (tctl_r[7:6] == gtm_pkg::CS_EXT);
  assign tick = (tctl_r[7:6] == gtm_pkg::CS_EXT) ?
    (ext_s & ~ext_q_r) : 1'b1;
  assign run = tctl_r[gtm_pkg::TC_ON] &
    (~gctl_r[gtm_pkg::GC_MODE] | gate_ok);
  assign inc  = run & tick & (~SLEEP_I | async_ext);
  assign wrap = inc & (cnt_r == gtm_pkg::CNT_MAX);

  // priority: byte write, then trigger clear, then increment
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_cnt) begin
      if (wr_lo) cnt_nxt[7:0] = WDATA_I;
      if (wr_hi) cnt_nxt[15:8] = WDATA_I;
    end else if (CONV_TRIG_I) begin
      cnt_nxt = gtm_pkg::RST_WORD;
    end else if (inc) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // counter plus edge history of the synchronised count pin
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_r   <= gtm_pkg::RST_WORD;
      ext_q_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ext_q_r <= ext_s;
    end
  end

  // ****************************************
  // flags: a set in the clearing cycle wins
  // ****************************************
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ovf_r <= 1'b0;
      gev_r <= 1'b0;
    end else begin
      // trigger clear suppresses wrap since it overrides the increment
      if (wrap & ~wr_cnt & ~CONV_TRIG_I) ovf_r <= 1'b1;
      else if (wr_fl & WDATA_I[gtm_pkg::FL_OVF]) ovf_r <= 1'b0;
      // independent of gate mode enable
      if (gate_fall) gev_r <= 1'b1;
      else if (wr_fl & WDATA_I[gtm_pkg::FL_GEV]) gev_r <= 1'b0;
    end
  end

  // ****************************************
  // capture/compare time base
  // ****************************************
  // match is a level; the registered copy turns it into one pulse
  assign eq_w = (ccv_r == cnt_r);

  // software byte write beats a capture landing in the same cycle
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ccv_r     <= gtm_pkg::RST_WORD;
      eq_q_r    <= 1'b0;
      COMPARE_O <= 1'b0;
    end else begin
      if (wr_cl | wr_ch) begin
        if (wr_cl) ccv_r[7:0] <= WDATA_I;
        if (wr_ch) ccv_r[15:8] <= WDATA_I;
      end else if (CAPTURE_I) begin
        ccv_r <= cnt_r;
      end
      eq_q_r    <= eq_w;
      COMPARE_O <= eq_w & ~eq_q_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign COUNT_O = cnt_r;
  // vectoring requires both global and peripheral enables
  assign IRQ_O = en_r[gtm_pkg::EN_GIE] & en_r[gtm_pkg::EN_PIE] &
    ((ovf_r & en_r[gtm_pkg::EN_OVFIE]) |
     (gev_r & en_r[gtm_pkg::EN_GEVIE]));
  // wake does not need global enable; core resumes in line
  assign WAKE_O = SLEEP_I & en_r[gtm_pkg::EN_PIE] &
    ovf_r & en_r[gtm_pkg::EN_OVFIE];
  // oscillator request ignores sleep and sync setting
  assign SOSC_RUN_O = tctl_r[gtm_pkg::TC_SOSC];

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  cmp_direct_a: assert property (
    gctl_r[1:0] == gtm_pkg::SRC_CMP1 && !en_r[gtm_pkg::EN_C1SYNC]
    |-> gate_src == CMP1_I) else $error("comparator 1 not passed direct");
  wrap_flag_a: assert property (
    wrap && !wr_cnt && !CONV_TRIG_I |=> ovf_r && cnt_r == 16'h0000)
    else $error("wrap did not zero counter and set overflow");
  trig_clear_a: assert property (
    CONV_TRIG_I && !wr_cnt && !ovf_r |=> cnt_r == 16'h0000 && !ovf_r)
    else $error("trigger did not clear quietly");
  write_wins_a: assert property (
    CONV_TRIG_I && wr_lo |=> cnt_r[7:0] == $past(WDATA_I))
    else $error("trigger overrode counter write");
  arm_clear_a: assert property (
    gate_done && !wr_gc |=> !arm_r) else $error("arm not self-cleared");
  gate_event_a: assert property (
    gate_fall |=> gev_r) else $error("gate event flag not set");
  gate_irq_a: assert property (
    gev_r && en_r[gtm_pkg::EN_GEVIE] && en_r[gtm_pkg::EN_GIE] &&
    en_r[gtm_pkg::EN_PIE] |-> IRQ_O) else $error("gate irq missing");
  gate_hold_a: assert property (
    gctl_r[gtm_pkg::GC_MODE] && !gate_ok && !wr_cnt && !CONV_TRIG_I
    |=> $stable(cnt_r)) else $error("counted with gate closed");
  off_hold_a: assert property (
    !tctl_r[gtm_pkg::TC_ON] && !wr_cnt && !CONV_TRIG_I
    |=> $stable(cnt_r)) else $error("counted while off");
  sleep_hold_a: assert property (
    SLEEP_I && !async_ext && !wr_cnt && !CONV_TRIG_I
    |=> $stable(cnt_r)) else $error("counted in sleep while synchronous");
  capture_a: assert property (
    CAPTURE_I && !wr_cl && !wr_ch |=> ccv_r == $past(cnt_r))
    else $error("capture did not copy counter");
  // guards on the synchronised source, arm hold, time base, global irq, wake path and oscillator
  cmp_sync_a: assert property (
    gctl_r[1:0] == gtm_pkg::SRC_CMP2 && en_r[gtm_pkg::EN_C2SYNC]
    |-> gate_src == c2_s) else $error("comparator 2 not synchronised");
  arm_hold_a: assert property (
    gctl_r[gtm_pkg::GC_MODE] && gctl_r[gtm_pkg::GC_SP] && !arm_r &&
    !wr_cnt && !CONV_TRIG_I |=> $stable(cnt_r))
    else $error("counted while disarmed");
  compare_pulse_a: assert property (
    eq_w && !eq_q_r |=> COMPARE_O) else $error("compare event missing");
  irq_global_a: assert property (
    !en_r[gtm_pkg::EN_GIE] |-> !IRQ_O) else $error("irq without global");
  wake_ovf_a: assert property (
    SLEEP_I && ovf_r && en_r[gtm_pkg::EN_PIE] && en_r[gtm_pkg::EN_OVFIE]
    |-> WAKE_O) else $error("overflow did not wake");
  sosc_sleep_a: assert property (
    SLEEP_I && tctl_r[gtm_pkg::TC_SOSC] |-> SOSC_RUN_O)
    else $error("oscillator stopped in sleep");
endmodule // gtm_timer

// *** tb/gtm_far_model.sv ***
// far-side model: 8-bit timer overflow, capture and trigger sources
module gtm_far_model (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic t0_run_i,
  input  wire logic cap_req_i,
  input  wire logic trig_req_i,
  input  wire logic auto_trig_i,
  input  wire logic compare_i,
  output logic      tmr0_ovf_o,
  output logic      capture_o,
  output logic      conv_trig_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] t0_cnt_r;

  // ****************************************
  // 8-bit neighbour timer
  // ****************************************
  // free count only while asked to run, so the gate source stays quiet
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t0_cnt_r <= 8'h00;
    end else if (t0_run_i) begin
      t0_cnt_r <= t0_cnt_r + 8'h01;
    end
  end

  // one-cycle pulse as the count passes from ff to 00
  assign tmr0_ovf_o = t0_run_i & (t0_cnt_r == 8'hFF);

  // ****************************************
  // capture/compare unit
  // ****************************************
  // in trigger mode a match comes straight back as a counter clear
  assign conv_trig_o = trig_req_i | (auto_trig_i & compare_i);
  assign capture_o   = cap_req_i;
endmodule // gtm_far_model

// *** tb/gated_16bit_timer_gate_logic_bench.sv ***
// self-checking bench for the gated 16-bit timer
module gated_16bit_timer_gate_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, nrst, wr, rd, pin, ext, cmp1, cmp2, sleep;
  logic        t0_run, cap_req, trig_req, auto_trig;
  logic        compare, irq, wake, sosc, tmr0, cap, trig;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] count, c;
  int          errors, checked, cmp_seen;

  gtm_timer i_gtm_timer (
    .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GATE_PIN_I(pin),
    .EXT_COUNT_I(ext), .TMR0_OVF_I(tmr0), .CMP1_I(cmp1), .CMP2_I(cmp2),
    .SLEEP_I(sleep), .CAPTURE_I(cap), .CONV_TRIG_I(trig),
    .COUNT_O(count), .COMPARE_O(compare), .IRQ_O(irq), .WAKE_O(wake),
    .SOSC_RUN_O(sosc));

  gtm_far_model i_gtm_far_model (
    .clk_i(clk), .nrst_i(nrst), .t0_run_i(t0_run), .cap_req_i(cap_req),
    .trig_req_i(trig_req), .auto_trig_i(auto_trig), .compare_i(compare),
    .tmr0_ovf_o(tmr0), .capture_o(cap), .conv_trig_o(trig));

  // ****************************************
  // clock, watchdog and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the whole sequence needs under two thousand cycles; this is ample
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end

  always @(posedge clk) if (compare === 1'b1) cmp_seen++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata & m}, {8'h00, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // pin held long enough to pass the three-stage synchroniser
  task automatic pin_pulse();
    @(posedge clk);
    pin <= 1'b1;
    repeat (10) @(posedge clk);
    pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {wr, rd, pin, ext, cmp1, cmp2, sleep} = '0;
    {t0_run, cap_req, trig_req, auto_trig} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    errors = 0;
    checked = 0;
    cmp_seen = 0;
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // polarity low with the pin low means the gate level reads high
    for (int a = 0; a < 8; a++)
      rd_chk(3'(a), 8'hFF, (a == 1) ? 8'h04 : 8'h00);
    // two increments from ffff: one wrap, one step past it
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'hFF);
    wr_reg(gtm_pkg::OFF_COUNT_HIGH, 8'hFF);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h01);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h00);
    idle(1);
    chk(count, 16'h0001);
    rd_chk(gtm_pkg::OFF_FLAGS, 8'h01, 8'h01);
    wr_reg(gtm_pkg::OFF_ENABLES, 8'hC1);
    idle(1);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(gtm_pkg::OFF_ENABLES, 8'h41);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    sleep <= 1'b1;
    idle(1);
    chk({15'h0000, wake}, 16'h0001);
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(gtm_pkg::OFF_FLAGS, 8'h01);
    rd_chk(gtm_pkg::OFF_FLAGS, 8'h01, 8'h00);
    // gate level and event flag with gate mode off
    wr_reg(gtm_pkg::OFF_ENABLES, 8'h04);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h40);
    @(posedge clk);
    pin <= 1'b1;
    idle(8);
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h04, 8'h04);
    // the polarity change dropped the level; only the pin fall may set it
    wr_reg(gtm_pkg::OFF_FLAGS, 8'h02);
    rd_chk(gtm_pkg::OFF_FLAGS, 8'h02, 8'h00);
    @(posedge clk);
    pin <= 1'b0;
    idle(8);
    rd_chk(gtm_pkg::OFF_FLAGS, 8'h02, 8'h02);
    wr_reg(gtm_pkg::OFF_ENABLES, 8'hC6);
    idle(1);
    chk({15'h0000, irq}, 16'h0001);
    // comparator 2 synchronised from here on, comparator 1 direct
    wr_reg(gtm_pkg::OFF_ENABLES, 8'hC8);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    // toggle flop: polarity already settled before toggle goes on
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h60);
    pin_pulse();
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h04, 8'h04);
    pin_pulse();
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h04, 8'h00);
    pin_pulse();
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h40);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h60);
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h04, 8'h00);
    // gated counting, pin as source, high level counts
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'h00);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h01);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'hC0);
    idle(10);
    c = count;
    idle(10);
    chk(count, c);
    @(posedge clk);
    pin <= 1'b1;
    idle(10);
    chk({15'h0000, count > c}, 16'h0001);
    @(posedge clk);
    pin <= 1'b0;
    // single pulse: enable first, then arm
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h00);
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'h00);
    wr_reg(gtm_pkg::OFF_COUNT_HIGH, 8'h00);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h01);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'hD0);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'hD8);
    idle(5);
    chk(count, 16'h0000);
    pin_pulse();
    idle(1);
    c = count;
    chk({15'h0000, c > 16'h0000}, 16'h0001);
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h08, 8'h00);
    pin_pulse();
    idle(1);
    chk(count, c);
    // toggle and single pulse together span a full gate cycle
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'hF0);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'hF8);
    pin_pulse();
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h08, 8'h08);
    pin_pulse();
    rd_chk(gtm_pkg::OFF_GATE_CTRL, 8'h08, 8'h00);
    wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h40);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h00);
    // other sources: timer overflow, comparator 1 direct, 2 synced
    for (int s = 1; s < 4; s++) begin
      wr_reg(gtm_pkg::OFF_GATE_CTRL, 8'h40 | 8'(s));
      wr_reg(gtm_pkg::OFF_FLAGS, 8'h03);
      @(posedge clk);
      case (s)
        1: t0_run <= 1'b1;
        2: cmp1 <= 1'b1;
        default: cmp2 <= 1'b1;
      endcase
      repeat (300) @(posedge clk);
      {t0_run, cmp1, cmp2} <= 3'b000;
      idle(8);
      rd_chk(gtm_pkg::OFF_FLAGS, 8'h02, 8'h02);
    end
    // sleep: synchronous mode stalls, asynchronous external counts
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'h00);
    @(posedge clk);
    sleep <= 1'b1;
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h01);
    idle(10);
    chk(count, 16'h0000);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h8D);
    repeat (3) begin
      @(posedge clk);
      ext <= 1'b1;
      repeat (6) @(posedge clk);
      ext <= 1'b0;
      repeat (6) @(posedge clk);
    end
    idle(2);
    chk(count, 16'h0003);
    chk({15'h0000, sosc}, 16'h0001);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h00);
    sleep <= 1'b0;
    // capture copy, then compare match used as period clear
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'h10);
    @(posedge clk);
    cap_req <= 1'b1;
    @(posedge clk);
    cap_req <= 1'b0;
    rd_chk(gtm_pkg::OFF_CCV_LOW, 8'hFF, 8'h10);
    rd_chk(gtm_pkg::OFF_CCV_HIGH, 8'hFF, 8'h00);
    wr_reg(gtm_pkg::OFF_CCV_LOW, 8'h14);
    wr_reg(gtm_pkg::OFF_COUNT_LOW, 8'h00);
    wr_reg(gtm_pkg::OFF_FLAGS, 8'h03);
    cmp_seen = 0;
    auto_trig <= 1'b1;
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h01);
    idle(200);
    chk({15'h0000, count <= 16'h0016}, 16'h0001);
    chk({15'h0000, cmp_seen > 0}, 16'h0001);
    rd_chk(gtm_pkg::OFF_FLAGS, 8'h01, 8'h00);
    wr_reg(gtm_pkg::OFF_TIMER_CTRL, 8'h00);
    auto_trig <= 1'b0;
    // a byte write landing with a trigger clear keeps the written byte
    wr_reg(gtm_pkg::OFF_COUNT_HIGH, 8'h12);
    @(posedge clk);
    addr     <= gtm_pkg::OFF_COUNT_LOW;
    wdata    <= 8'h55;
    wr       <= 1'b1;
    trig_req <= 1'b1;
    @(posedge clk);
    wr       <= 1'b0;
    trig_req <= 1'b0;
    idle(1);
    chk(count, 16'h1255);
    wrap_up();
  end
endmodule // gated_16bit_timer_gate_logic_bench
